// ===== hdl/lccs_core.sv
// Purpose: Directed link change handling and config space mirror outputs
// Assumes: All inputs synchronous to clk; config writes arrive decoded
// Notes:   Mirrors are read-only to the application; status mirror is unsupported
`timescale 1ns/1ps

module lccs_core
    import lccs_pkg::*;
#(
    parameter bit IS_ROOT = 1'b0
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire lccs_cfgwr_t cfg_wr,
    input  wire lccs_dreq_t  dreq,
    input  wire logic        link_up,
    input  wire logic [5:0]  training_state_code,
    input  wire logic [1:0]  power_state,
    input  wire logic [2:0]  link_power_state,
    input  wire logic [15:0] link_control,
    input  wire logic        lane_reversal,
    input  wire logic        local_second_rate_capable,
    input  wire logic        partner_second_rate_capable,
    input  wire logic [1:0]  root_auto_speed_attr,
    input  wire logic [3:0]  mutual_width_mask,
    input  wire logic [1:0]  initial_width_report,
    input  wire logic        width_upsize_capable,
    input  wire logic        mem_request_in,
    input  wire logic        io_request_in,
    input  wire logic        app_request_out,
    output logic [15:0]      header_command_mirror,
    output logic [7:0]       bus_id,
    output logic [4:0]       device_id,
    output logic [2:0]       function_id,
    output logic [15:0]      status_mirror,
    output logic [1:0]       current_width,
    output logic             current_speed_fast,
    output logic             change_busy,
    output logic             change_rejected,
    output logic             mem_accept,
    output logic             io_accept,
    output logic             request_blocked
);
    typedef enum {LCCS_IDLE, LCCS_TRAIN, LCCS_DONE} lccs_state_t;

    function automatic logic lccs_ready(input logic up, input logic [5:0] st,
                                        input logic [1:0] pw, input logic [2:0] lps);
        lccs_ready = up && (st == LCCS_L0_STATE) && (pw == LCCS_PWR_D0)
                     && (lps != LCCS_LPS_L1_TRANS) && (lps != LCCS_LPS_L23_TRANS);
    endfunction

    lccs_state_t  state_q,  state_d;
    logic [15:0]  cmd_q,    cmd_d;
    logic [7:0]   bus_q,    bus_d;
    logic [4:0]   dev_q,    dev_d;
    logic [1:0]   width_q,  width_d;
    logic         fast_q,   fast_d;
    logic         rej_q,    rej_d;
    logic         mem_q,    mem_d;
    logic         io_q,     io_d;
    logic         blk_q,    blk_d;
    logic [4:0]   age_q,    age_d;
    logic [1:0]   pick;
    logic         pick_ok;
    logic         width_req;
    logic         speed_req;
    logic         accept_req;

    lccs_width_pick u_pick
    (
        .requested   (dreq.target_width),
        .current     (width_q),
        .initial_w   (initial_width_report),
        .upsize_ok   (width_upsize_capable),
        .mutual_mask (mutual_width_mask),
        .granted     (pick),
        .legal       (pick_ok)
    );

    assign width_req = dreq.change[0];
    assign speed_req = dreq.change[1];

    // Config mirror group
    always_comb
    begin
        cmd_d = cmd_q;
        bus_d = bus_q;
        dev_d = dev_q;
        if (cfg_wr.valid && cfg_wr.type0)
        begin
            bus_d = cfg_wr.bus;
            dev_d = cfg_wr.dev;
        end
        // Only writable bits land; hardwired and reserved bits stay zero
        if (cfg_wr.valid && cfg_wr.cmd_hit)
            cmd_d = cfg_wr.cmd_data & LCCS_CMD_WMASK;
        mem_d = mem_request_in && cmd_q[LCCS_CMD_MEM_EN];
        io_d  = io_request_in && cmd_q[LCCS_CMD_IO_EN];
        // Flag only; bus master is not enforced on the transmit path
        blk_d = app_request_out && !cmd_q[LCCS_CMD_BM_EN];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_q <= LCCS_CMD_RESET;
            bus_q <= LCCS_BUS_RESET;
            dev_q <= LCCS_DEV_RESET;
            mem_q <= 1'b0;
            io_q  <= 1'b0;
            blk_q <= 1'b0;
        end
        else
        begin
            cmd_q <= cmd_d;
            bus_q <= bus_d;
            dev_q <= dev_d;
            mem_q <= mem_d;
            io_q  <= io_d;
            blk_q <= blk_d;
        end
    end

    // Directed change group
    always_comb
    begin
        state_d    = state_q;
        width_d    = width_q;
        fast_d     = fast_q;
        rej_d      = 1'b0;
        age_d      = age_q;
        accept_req = 1'b0;
        // Preconditions may be sampled up to the window before the request
        if (lccs_ready(link_up, training_state_code, power_state, link_power_state))
            age_d = '0;
        else if (age_q != 5'(LCCS_PRECOND_WINDOW + 1))
            age_d = age_q + 5'h1;
        case (state_q)
            LCCS_IDLE:
            begin
                if (dreq.change != LCCS_DC_NONE)
                begin
                    accept_req = (age_q <= 5'(LCCS_PRECOND_WINDOW))
                        && dreq.auton
                        && !(width_req && (lane_reversal
                             || link_control[LCCS_LCTL_HAWD]
                             || dreq.target_width > initial_width_report
                             || !pick_ok))
                        && !(speed_req && dreq.target_speed
                             && !(local_second_rate_capable
                                  && partner_second_rate_capable))
                        && !(IS_ROOT && speed_req
                             && root_auto_speed_attr != LCCS_ROOT_SPD_AUTO);
                    if (accept_req)
                    begin
                        if (width_req)
                            width_d = pick;
                        if (speed_req)
                            fast_d = dreq.target_speed;
                        state_d = LCCS_TRAIN;
                    end
                    else
                        rej_d = 1'b1;
                end
            end
            LCCS_TRAIN:
            begin
                if (training_state_code == LCCS_L0_STATE)
                    state_d = LCCS_DONE;
            end
            LCCS_DONE:
            begin
                // Wait for release so a held request is not taken twice
                if (dreq.change == LCCS_DC_NONE)
                    state_d = LCCS_IDLE;
            end
            default:
                state_d = LCCS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= LCCS_IDLE;
            width_q <= LCCS_W_X8;
            fast_q  <= 1'b0;
            rej_q   <= 1'b0;
            age_q   <= 5'(LCCS_PRECOND_WINDOW + 1);
        end
        else
        begin
            state_q <= state_d;
            width_q <= width_d;
            fast_q  <= fast_d;
            rej_q   <= rej_d;
            age_q   <= age_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            change_busy <= 1'b0;
        else
            change_busy <= (state_d != LCCS_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            function_id   <= LCCS_FUNC_FIXED;
            status_mirror <= LCCS_STATUS_NONE;
        end
        else
        begin
            function_id   <= LCCS_FUNC_FIXED;
            status_mirror <= LCCS_STATUS_NONE;
        end
    end

    assign header_command_mirror = cmd_q;
    assign bus_id                = bus_q;
    assign device_id             = dev_q;
    assign current_width         = width_q;
    assign current_speed_fast    = fast_q;
    assign change_rejected       = rej_q;
    assign mem_accept            = mem_q;
    assign io_accept             = io_q;
    assign request_blocked       = blk_q;
endmodule // lccs_core

// ===== hdl/lccs_pkg.sv
// Purpose: Shared constants and carriers for link change and config status mirror
// Assumes: Single user clock, 16-bit config register mirrors
// Notes:   Command bit positions follow the header command layout
package lccs_pkg;

    localparam logic [5:0] LCCS_L0_STATE        = 6'h16;
    localparam logic [1:0] LCCS_PWR_D0          = 2'h0;
    localparam logic [2:0] LCCS_LPS_L1_TRANS    = 3'h5;
    localparam logic [2:0] LCCS_LPS_L23_TRANS   = 3'h6;
    localparam logic [1:0] LCCS_ROOT_SPD_AUTO   = 2'h3;
    localparam int         LCCS_PRECOND_WINDOW  = 16;

    localparam int LCCS_CMD_IO_EN    = 0;
    localparam int LCCS_CMD_MEM_EN   = 1;
    localparam int LCCS_CMD_BM_EN    = 2;
    localparam int LCCS_CMD_SERR_EN  = 8;
    localparam int LCCS_CMD_INTX_DIS = 10;
    localparam int LCCS_LCTL_HAWD    = 9;

    localparam logic [15:0] LCCS_CMD_WMASK   = 16'h0507;
    localparam logic [15:0] LCCS_CMD_RESET   = 16'h0000;
    localparam logic [7:0]  LCCS_BUS_RESET   = 8'h00;
    localparam logic [4:0]  LCCS_DEV_RESET   = 5'h00;
    localparam logic [2:0]  LCCS_FUNC_FIXED  = 3'h0;
    localparam logic [15:0] LCCS_STATUS_NONE = 16'h0000;

    // Width codes: 1, 2, 4, 8 lanes as a binary index 0..3
    localparam logic [1:0] LCCS_W_X1 = 2'h0;
    localparam logic [1:0] LCCS_W_X8 = 2'h3;

    // Directed change request encoding
    localparam logic [1:0] LCCS_DC_NONE  = 2'h0;
    localparam logic [1:0] LCCS_DC_WIDTH = 2'h1;
    localparam logic [1:0] LCCS_DC_SPEED = 2'h2;
    localparam logic [1:0] LCCS_DC_BOTH  = 2'h3;

    typedef struct packed {
        logic       valid;
        logic       type0;
        logic [7:0] bus;
        logic [4:0] dev;
        logic       cmd_hit;
        logic [15:0] cmd_data;
    } lccs_cfgwr_t;

    typedef struct packed {
        logic [1:0] change;
        logic [1:0] target_width;
        logic       target_speed;
        logic       auton;
    } lccs_dreq_t;

endpackage

// ===== hdl/lccs_width_pick.sv
// Purpose: Resolve a requested link width against mutually supported widths
// Assumes: Width codes 0..3 mean 1, 2, 4, 8 lanes
// Notes:   Pure combinational; the caller registers the result
`timescale 1ns/1ps
module lccs_width_pick
    import lccs_pkg::*;
(
    input  wire logic [1:0] requested,
    input  wire logic [1:0] current,
    input  wire logic [1:0] initial_w,
    input  wire logic       upsize_ok,
    input  wire logic [3:0] mutual_mask,
    output logic      [1:0] granted,
    output logic            legal
);
    logic [1:0] ceiling;
    logic       found;

    always_comb
    begin
        // With upsize the ceiling is the initial width, else strictly below current
        ceiling = upsize_ok ? initial_w : current;
        granted = current;
        found   = 1'b0;
        legal   = 1'b0;
        if (upsize_ok || (requested < current))
        begin
            // Walk down to the widest mutual width at or below both request and ceiling
            for (int i = 3; i >= 0; i--)
            begin
                if (!found && (2'(i) <= requested) && (2'(i) <= ceiling)
                    && mutual_mask[i])
                begin
                    granted = 2'(i);
                    found   = 1'b1;
                end
            end
            if (!upsize_ok && granted >= current)
                found = 1'b0;
            legal = found;
            if (!found)
                granted = current;
        end
    end
endmodule // lccs_width_pick

// ===== verification/lccs_core_props.sv
// Purpose: Port checks for lccs_core
// Assumes: One clock, async active-low reset
// Notes:   Mirrors and the memory and I/O gates only; the change flow is judged by the bench model
`timescale 1ns/1ps
module lccs_core_props
    import lccs_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire lccs_cfgwr_t cfg_wr,
    input wire logic        mem_request_in,
    input wire logic        io_request_in,
    input wire logic [15:0] header_command_mirror,
    input wire logic [7:0]  bus_id,
    input wire logic [4:0]  device_id,
    input wire logic [2:0]  function_id,
    input wire logic [15:0] status_mirror,
    input wire logic        mem_accept,
    input wire logic        io_accept
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    fid_zero_a: assert property (function_id == 3'h0)
        else $error("function id set");
    status_zero_a: assert property (status_mirror == 16'h0000)
        else $error("status set");
    cmd_fixed_a: assert property ((header_command_mirror & 16'hFAF8) == 16'h0000)
        else $error("fixed command bit set");
    cmd_write_a: assert property (cfg_wr.valid && cfg_wr.cmd_hit |=>
        header_command_mirror == ($past(cfg_wr.cmd_data) & 16'h0507))
        else $error("command write lost");
    id_capture_a: assert property (cfg_wr.valid && cfg_wr.type0 |=>
        {bus_id, device_id} == $past({cfg_wr.bus, cfg_wr.dev}))
        else $error("ids not captured");
    id_hold_a: assert property (!(cfg_wr.valid && cfg_wr.type0) |=>
        $stable({bus_id, device_id}))
        else $error("ids moved");
    mem_gate_a: assert property (
        mem_accept == $past(mem_request_in & header_command_mirror[1]))
        else $error("memory gate wrong");
    io_gate_a: assert property (
        io_accept == $past(io_request_in & header_command_mirror[0]))
        else $error("io gate wrong");
endmodule // lccs_core_props

bind lccs_core lccs_core_props u_props (
    .clk, .reset_n, .cfg_wr, .mem_request_in, .io_request_in, .header_command_mirror,
    .bus_id, .device_id, .function_id, .status_mirror, .mem_accept, .io_accept
);

// ===== verification/lccs_app_model.sv
// Purpose: Application sequencer model issuing directed link changes
// Assumes: Bench sets go and the wanted request; rogue skips every check
// Notes:   Request held while go is high; bench releases it after L0
`timescale 1ns/1ps
module lccs_app_model
    import lccs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        go,
    input  wire logic        rogue,
    input  wire lccs_dreq_t  want,
    input  wire logic        up,
    input  wire logic [5:0]  tsc,
    input  wire logic [1:0]  pw,
    input  wire logic [2:0]  lps,
    input  wire logic [15:0] lctl,
    input  wire logic        rev,
    input  wire logic        cap_l,
    input  wire logic        cap_p,
    output lccs_dreq_t       dreq
);
    logic [4:0] age_q;
    logic [4:0] age_d;
    logic       ready;
    logic       ok;

    always_comb
    begin
        ready = up && tsc == LCCS_L0_STATE && pw == LCCS_PWR_D0
            && !lctl[LCCS_LCTL_HAWD] && lps != LCCS_LPS_L1_TRANS
            && lps != LCCS_LPS_L23_TRANS;
        age_d = ready ? 5'h00 : (age_q == 5'h1F ? age_q : age_q + 5'h01);
        // Stricter than the 16-cycle allowance so a late check never slips through
        ok = age_q < 5'h10 && !(want.change[0] && rev)
            && !(want.change[1] && want.target_speed && !(cap_l && cap_p));
        dreq = (go && (ok || rogue)) ? want : '0;
        dreq.auton = dreq.auton | (go & ~rogue);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            age_q <= 5'h1F;
        else
            age_q <= age_d;
    end
endmodule // lccs_app_model

// ===== verification/lccs_core_tb.sv
// Purpose: Self-checking bench for lccs_core
// Assumes: Endpoint build with a root build alongside, inputs driven at the falling edge
// Notes:   Endpoint refusals are provoked through the rogue path of the app model
`timescale 1ns/1ps
module lccs_core_tb
    import lccs_pkg::*;
();
    logic        clk, reset_n, go, rogue, upc, rev, capp, memr, ior, em, ei;
    logic        lup, capl, appr, ep;
    logic        busy, rej, speed, macc, iacc, blk, busy_rp;
    logic [1:0]  pw, init, cw_o, rattr;
    logic [2:0]  lps, fid;
    logic [3:0]  mask;
    logic [4:0]  dev;
    logic [5:0]  tsc;
    logic [7:0]  bus;
    logic [15:0] lctl, cmd, stat;
    lccs_cfgwr_t wr;
    lccs_dreq_t  want, dreq;
    int          bad_count, n_compared, eb, ed, ec, cw, cs, age;

    lccs_core DUT (
        .clk(clk), .reset_n(reset_n), .cfg_wr(wr), .dreq(dreq), .link_up(lup),
        .training_state_code(tsc), .power_state(pw), .link_power_state(lps),
        .link_control(lctl), .lane_reversal(rev), .local_second_rate_capable(capl),
        .partner_second_rate_capable(capp), .root_auto_speed_attr(rattr),
        .mutual_width_mask(mask), .initial_width_report(init), .width_upsize_capable(upc),
        .mem_request_in(memr), .io_request_in(ior), .app_request_out(appr),
        .header_command_mirror(cmd), .bus_id(bus), .device_id(dev), .function_id(fid),
        .status_mirror(stat), .current_width(cw_o), .current_speed_fast(speed),
        .change_busy(busy), .change_rejected(rej), .mem_accept(macc), .io_accept(iacc),
        .request_blocked(blk)
    );
    // Root build sees the same stimulus; only its speed gate differs
    lccs_core #(.IS_ROOT(1'b1)) DUT_RP (
        .clk(clk), .reset_n(reset_n), .cfg_wr(wr), .dreq(dreq), .link_up(lup),
        .training_state_code(tsc), .power_state(pw), .link_power_state(lps),
        .link_control(lctl), .lane_reversal(rev), .local_second_rate_capable(capl),
        .partner_second_rate_capable(capp), .root_auto_speed_attr(rattr),
        .mutual_width_mask(mask), .initial_width_report(init), .width_upsize_capable(upc),
        .mem_request_in(memr), .io_request_in(ior), .app_request_out(appr),
        .header_command_mirror(), .bus_id(), .device_id(), .function_id(),
        .status_mirror(), .current_width(), .current_speed_fast(),
        .change_busy(busy_rp), .change_rejected(), .mem_accept(), .io_accept(),
        .request_blocked()
    );
    lccs_app_model u_app (
        .clk(clk), .reset_n(reset_n), .go(go), .rogue(rogue), .want(want), .up(lup),
        .tsc(tsc), .pw(pw), .lps(lps), .lctl(lctl), .rev(rev), .cap_l(capl), .cap_p(capp),
        .dreq(dreq)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycles since the preconditions last held together, saturating past the allowance
    always @(posedge clk)
        age <= !reset_n ? 17 : (lup && tsc == LCCS_L0_STATE && pw == 2'h0 && lps != 3'h5
            && lps != 3'h6) ? 0 : (age < 17 ? age + 1 : 17);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Model picks the widest mutual width not above request and ceiling
    task automatic dc(input logic [1:0] c, input logic [1:0] tw, input logic ts,
                      input logic au, input logic rg);
        int g;
        int ok;
        int k;
        g = -1;
        for (int i = 0; i < 4; i++)
            if (mask[i] && i <= tw && i <= (upc ? init : cw))
                g = i;
        ok = au && age <= 16;
        if (c[0])
            ok = ok && !rev && !lctl[9] && tw <= init && g >= 0 && (upc || g < cw);
        if (c[1] && ts)
            ok = ok && capp && capl;
        want = '{c, tw, ts, au};
        rogue = rg;
        go = 1'b1;
        k = 0;
        while (busy !== 1'b1 && rej !== 1'b1 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 40)
        begin
            bad_count++;
            $display("[FAIL] %0t no answer", $time);
            summarize();
        end
        chk(busy, ok);
        chk(busy_rp, ok && !(c[1] && rattr != 2'h3));
        if (ok)
        begin
            cw = c[0] ? g : cw;
            cs = c[1] ? ts : cs;
            tsc = 6'h00;
            @(negedge clk);
            tsc = LCCS_L0_STATE;
            @(negedge clk);
        end
        chk({cw_o, speed}, {cw[1:0], cs[0]});
        go = 1'b0;
        repeat (2) @(negedge clk);
        chk(busy, 0);
        $display("change %0d done", c);
    endtask

    initial
    begin
        void'($urandom(32'h6F9377CE));
        {go, rogue, upc, rev, capp, memr, ior, appr, wr, want} = '0;
        {lup, capl, rattr} = 4'hF;
        {reset_n, pw, lps, lctl, mask, init} = {1'b0, 21'h0, 4'hF, 2'h3};
        tsc = LCCS_L0_STATE;
        {bad_count, n_compared, eb, ed, ec, cs} = '0;
        cw = 3;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        chk({bus, dev, cmd, cw_o}, 2'h3);
        for (int i = 0; i < 64; i++)
        begin
            wr = 32'($urandom);
            {memr, ior, appr} = 3'($urandom);
            em = memr & ec[1];
            ei = ior & ec[0];
            ep = appr & ~ec[2];
            eb = (wr.valid && wr.type0) ? wr.bus : eb;
            ed = (wr.valid && wr.type0) ? wr.dev : ed;
            ec = (wr.valid && wr.cmd_hit) ? (wr.cmd_data & 16'h0507) : ec;
            @(negedge clk);
            chk({bus, dev, cmd, macc, iacc, blk},
                {eb[7:0], ed[4:0], ec[15:0], em, ei, ep});
            chk({fid, stat}, 0);
        end
        $display("config test done");
        {wr, memr, ior, appr} = '0;
        mask = 4'h9;
        dc(2'h1, 2'h2, 1'b0, 1'b1, 1'b0);
        dc(2'h1, 2'h2, 1'b0, 1'b1, 1'b1);
        mask = 4'hF;
        upc = 1'b1;
        dc(2'h1, 2'h3, 1'b0, 1'b1, 1'b0);
        rev = 1'b1;
        dc(2'h1, 2'h1, 1'b0, 1'b1, 1'b1);
        {rev, lctl} = {1'b0, 16'h0200};
        dc(2'h1, 2'h1, 1'b0, 1'b1, 1'b1);
        {lctl, init} = {16'h0000, 2'h2};
        dc(2'h1, 2'h3, 1'b0, 1'b1, 1'b1);
        init = 2'h3;
        dc(2'h1, 2'h1, 1'b0, 1'b0, 1'b1);
        dc(2'h2, 2'h0, 1'b1, 1'b1, 1'b1);
        {capp, capl} = 2'b10;
        dc(2'h2, 2'h0, 1'b1, 1'b1, 1'b1);
        capl = 1'b1;
        dc(2'h2, 2'h0, 1'b0, 1'b1, 1'b0);
        rattr = 2'h0;
        dc(2'h3, 2'($urandom), 1'b1, 1'b1, 1'b0);
        // Last pass asks at the very end of the 16-cycle allowance and must be taken
        for (int j = 0; j < 5; j++)
        begin
            {lup, pw, lps} = 6'h20;
            repeat (2) @(negedge clk);
            lup = (j != 3);
            {pw, lps} = (j == 0) ? 5'h18 : {2'h0, 3'((j == 4) ? 5 : j + 4)};
            repeat ((j == 4) ? 16 : 17) @(negedge clk);
            dc(2'h1, 2'h0, 1'b0, 1'b1, 1'b1);
        end
        summarize();
    end
endmodule // lccs_core_tb
